// File: hw/prescaled_8bit_reload_timer.sv
/*
 Prescaled 8-bit reload timer with its interrupt controller slice, event status and one pin.
 Assumes a single-master register port on clk; the pin arrives from outside and is synchronised.
*/
`include "reload_timer_regs.svh"
module prescaled_8bit_reload_timer
	import reload_timer_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	// Shared pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	// Request to the core
	output logic irq_req,
	output logic [2:0] irq_level,
	output logic [7:0] irq_vector,
	// Event interrupt
	output logic evt_irq
);
	////////////////////////////////////////////////////////////////
	// Declarations
	byte_t clk_src_reg;
	byte_t psc_ctrl_reg;
	byte_t reload_reg;
	byte_t count_reg;
	byte_t count_next;
	byte_t port_func_reg;
	byte_t port_data_reg;
	logic [2:0] prio_reg;
	logic int_en_reg;
	logic factor_reg;
	logic clkout_reg;
	logic tmr_out_reg;
	logic [2:0] evt_stat_reg;
	logic [2:0] evt_mask_reg;
	logic [2:0] evt_set;
	timer_state_t state_reg;
	timer_state_t state_next;
	logic pin_sync1_reg;
	logic pin_sync2_reg;
	logic pin_prev_reg;
	logic ext_edge;
	logic psc_tick;
	logic count_tick;
	logic wr_ctrl;
	logic preset_req;
	logic underflow;
	logic rd_stat;

	// Decoded strobes
	assign wr_ctrl = wr_stb & (addr == `A_TMR_CTRL);
	assign preset_req = wr_ctrl & wdata[`CTL_PRESET_BIT];
	assign rd_stat = rd_stb & (addr == `A_EVT_STAT);

	////////////////////////////////////////////////////////////////
	// Shared prescaler
	prescaler_divider u_psc (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.div_sel(psc_ctrl_reg[`PSC_DIV_MSB:0]),
		.gate_on(psc_ctrl_reg[`PSC_GATE_BIT]),
		.tick(psc_tick)
	);

	////////////////////////////////////////////////////////////////
	// Pin synchroniser and edge detect
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_sync1_reg <= 1'b0;
			pin_sync2_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else if (ce) begin
			pin_sync1_reg <= pin_in;
			pin_sync2_reg <= pin_sync1_reg;
			pin_prev_reg <= pin_sync2_reg;
		end
	end

	// Rising edge of the external count input
	assign ext_edge = pin_sync2_reg & ~pin_prev_reg;

	// Counting source: divided clock when select is zero
	always_comb begin
		if (clk_src_reg == `REG_RESET) begin
			count_tick = psc_tick;
		end else begin
			count_tick = ext_edge & port_func_reg[`PF_EXT_IN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_src_reg <= `REG_RESET;
			psc_ctrl_reg <= `REG_RESET;
			reload_reg <= `REG_RESET;
		end else if (ce && wr_stb) begin
			case (addr)
				`A_CLK_SRC: begin
					clk_src_reg <= wdata;
				end
				`A_PSC_CTRL: begin
					psc_ctrl_reg <= wdata;
				end
				`A_RELOAD: begin
					reload_reg <= wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Pin function and port data
	always_ff @(posedge clk) begin
		if (rst) begin
			port_func_reg <= `REG_RESET;
			port_data_reg <= `REG_RESET;
		end else if (ce && wr_stb) begin
			if (addr == `A_PORT_FUNC) begin
				port_func_reg <= wdata;
			end
			if (addr == `A_PORT_DATA) begin
				port_data_reg <= wdata;
			end
		end
	end

	// Interrupt controller settings
	always_ff @(posedge clk) begin
		if (rst) begin
			prio_reg <= '0;
			int_en_reg <= 1'b0;
			evt_mask_reg <= '0;
		end else if (ce && wr_stb) begin
			if (addr == `A_PRIO) begin
				prio_reg <= wdata[`PRIO_MSB:0];
			end
			if (addr == `A_INT_EN) begin
				int_en_reg <= wdata[`INT_EN_BIT];
			end
			if (addr == `A_EVT_MASK) begin
				evt_mask_reg <= wdata[2:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Run state; a control write sets or clears it in one step
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TMR_IDLE: begin
				if (wr_ctrl && wdata[`CTL_RUN_BIT]) begin
					state_next = TMR_RUN;
				end
			end
			TMR_RUN: begin
				if (wr_ctrl && !wdata[`CTL_RUN_BIT]) begin
					state_next = TMR_IDLE;
				end
			end
			default: begin
				state_next = TMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= TMR_IDLE;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// Clock-out enable held in the control register
	always_ff @(posedge clk) begin
		if (rst) begin
			clkout_reg <= 1'b0;
		end else if (ce && wr_ctrl) begin
			clkout_reg <= wdata[`CTL_CLKOUT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Down counter
	// Underflow only while running, on a tick, at zero, with no preset
	assign underflow = (state_reg == TMR_RUN) & count_tick & (count_reg == `COUNT_ZERO) & ~preset_req;

	always_comb begin
		count_next = count_reg;
		if (preset_req) begin
			count_next = reload_reg;
		end else if (state_reg == TMR_RUN && count_tick) begin
			if (count_reg == `COUNT_ZERO) begin
				count_next = reload_reg;
			end else begin
				count_next = count_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= `REG_RESET;
		end else if (ce) begin
			count_reg <= count_next;
		end
	end

	// Timer output toggles on every underflow while clock-out is on
	always_ff @(posedge clk) begin
		if (rst) begin
			tmr_out_reg <= 1'b0;
		end else if (ce && underflow && clkout_reg) begin
			tmr_out_reg <= ~tmr_out_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Factor flag: underflow sets it, writing one clears it, set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			factor_reg <= 1'b0;
		end else if (ce) begin
			if (underflow) begin
				factor_reg <= 1'b1;
			end else if (wr_stb && addr == `A_FACTOR && wdata[`FACTOR_BIT]) begin
				factor_reg <= 1'b0;
			end
		end
	end

	// Request to the core, held while the flag and the enable are both set
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_req <= 1'b0;
			irq_level <= '0;
		end else if (ce) begin
			irq_req <= factor_reg & int_en_reg;
			irq_level <= prio_reg;
		end
	end

	// Fixed vector for this source
	assign irq_vector = `TMR_VECTOR;

	////////////////////////////////////////////////////////////////
	// Event status: sticky, cleared by reading, set wins
	always_comb begin
		evt_set = '0;
		evt_set[`EVT_UNDERFLOW_BIT] = underflow;
		evt_set[`EVT_OVERRUN_BIT] = underflow & factor_reg;
		evt_set[`EVT_PRESET_BIT] = preset_req;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			evt_stat_reg <= '0;
		end else if (ce) begin
			if (rd_stat) begin
				evt_stat_reg <= evt_set;
			end else begin
				evt_stat_reg <= evt_stat_reg | evt_set;
			end
		end
	end

	// Level event interrupt while any unmasked bit is set
	assign evt_irq = |(evt_stat_reg & evt_mask_reg);

	////////////////////////////////////////////////////////////////
	// Pin drive: port by default, timer output once selected
	always_comb begin
		if (port_func_reg[`PF_TMR_OUT_BIT]) begin
			pin_out = tmr_out_reg;
			pin_oe_n = 1'b0;
		end else begin
			pin_out = port_data_reg[`PD_DATA_BIT];
			pin_oe_n = ~(port_func_reg[`PF_DIR_OUT_BIT] & ~port_func_reg[`PF_EXT_IN_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data, registered, valid the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= `REG_RESET;
		end else if (ce) begin
			rdata <= `REG_RESET;
			if (rd_stb) begin
				case (addr)
					`A_CLK_SRC: begin
						rdata <= clk_src_reg;
					end
					`A_PSC_CTRL: begin
						rdata <= psc_ctrl_reg;
					end
					`A_TMR_CTRL: begin
						rdata <= {5'h00, clkout_reg, 1'b0, state_reg == TMR_RUN};
					end
					`A_RELOAD: begin
						rdata <= reload_reg;
					end
					`A_COUNT: begin
						rdata <= count_reg;
					end
					`A_EVT_STAT: begin
						rdata <= {5'h00, evt_stat_reg};
					end
					`A_EVT_MASK: begin
						rdata <= {5'h00, evt_mask_reg};
					end
					`A_PRIO: begin
						rdata <= {5'h00, prio_reg};
					end
					`A_INT_EN: begin
						rdata <= {7'h00, int_en_reg};
					end
					`A_FACTOR: begin
						rdata <= {7'h00, factor_reg};
					end
					`A_PORT_FUNC: begin
						rdata <= port_func_reg;
					end
					`A_PORT_DATA: begin
						rdata <= {port_data_reg[7:1], pin_sync2_reg};
					end
					default: begin
						rdata <= `REG_RESET;
					end
				endcase
			end
		end
	end
endmodule

// File: hw/prescaler_divider.sv
/*
 Shared clock prescaler: free-running divider with selectable tap and a clock gate.
 Assumes one system clock; ce freezes the divider.
*/
`include "reload_timer_regs.svh"
module prescaler_divider
	import reload_timer_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Tap select and gate
	input wire logic [2:0] div_sel,
	input wire logic gate_on,
	// Divided tick, one cycle per 2^(div_sel+1) clocks
	output logic tick
);
	logic [`DIV_TAPS-1:0] cnt_reg;
	logic [`DIV_TAPS-1:0] tap;

	////////////////////////////////////////////////////////////////
	// Free-running divider
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (ce) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Tap i fires once every 2^(i+1) clocks
	genvar i;
	generate
		for (i = 0; i < `DIV_TAPS; i = i + 1) begin : g_tap
			assign tap[i] = &cnt_reg[i:0];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Gated, registered tick
	always_ff @(posedge clk) begin
		if (rst) begin
			tick <= 1'b0;
		end else if (ce) begin
			tick <= gate_on & tap[div_sel];
		end
	end
endmodule

// File: hw/reload_timer_pkg.sv
/*
 Types shared by the reload timer files.
 Assumes the constants header is included beside it.
*/
package reload_timer_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic {TMR_IDLE, TMR_RUN} timer_state_t;
endpackage

// File: hw/reload_timer_regs.svh
/*
 Register offsets, field positions and reset values for the prescaled 8-bit reload timer.
 Assumes an 8-bit register port addressed with 20-bit byte addresses, one register per address.
*/
// Contract
// - The timer counts only ticks of the shared divided prescaler clock, never the raw clock; a nonzero source select counts pin rising edges instead.
// - Timer requests go through the interrupt controller, which alone drives the core request; evt_irq raises timer events outside it, gated only by the event mask.
// - The pin comes up as a general-purpose input; timer functions need a function select.
// - Interrupt every reload plus one divided ticks; period is that times the prescaler ratio.
// - Prescaler control gates the divided clock: 0x7 stops it, 0x0f supplies it.
// - With the gate open and run clear, the counter stays idle.
// - Writing 0x3 to timer control presets the counter and starts it.
// - Preset and start work in either order, with the same result; the code stops the timer when a preset write of 0x02 comes after the start.
// - Writing 0x00 to timer control stops decrementing.
// - Clock source select zero picks the divided prescaler clock.
// - The controller holds a programmable priority level for the timer request.
// - Enable bit 0 must be set before the request reaches the core.
// - Controller keeps a factor flag; software clears it by writing 0x01.
// - The timer request uses hardware vector number 36.
`ifndef RELOAD_TIMER_REGS_SVH
`define RELOAD_TIMER_REGS_SVH

`define ADDR_W 20
`define A_CLK_SRC 20'h40146
`define A_PSC_CTRL 20'h4014D
`define A_TMR_CTRL 20'h40160
`define A_RELOAD 20'h40161
`define A_COUNT 20'h40162
`define A_EVT_STAT 20'h40170
`define A_EVT_MASK 20'h40171
`define A_PRIO 20'h40269
`define A_INT_EN 20'h40275
`define A_FACTOR 20'h40285
`define A_PORT_FUNC 20'h402E0
`define A_PORT_DATA 20'h402E1

`define REG_RESET 8'h00
`define PSC_DIV_MSB 2
`define PSC_GATE_BIT 3
`define CTL_RUN_BIT 0
`define CTL_PRESET_BIT 1
`define CTL_CLKOUT_BIT 2
`define PRIO_MSB 2
`define INT_EN_BIT 0
`define FACTOR_BIT 0
`define PF_TMR_OUT_BIT 0
`define PF_EXT_IN_BIT 1
`define PF_DIR_OUT_BIT 2
`define PD_DATA_BIT 0
`define EVT_UNDERFLOW_BIT 0
`define EVT_OVERRUN_BIT 1
`define EVT_PRESET_BIT 2
`define COUNT_ZERO 8'h00
`define TMR_VECTOR 8'h24
`define DIV_TAPS 8

`endif

// File: verification/prescaled_8bit_reload_timer_tb_top.sv
/*
 Directed testbench of the reload timer over its register port.
 Assumes the design and the checker are compiled before it.
*/
`include "reload_timer_regs.svh"
module prescaled_8bit_reload_timer_tb_top
	import reload_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, got;
	logic [`ADDR_W-1:0] addr = '0;
	byte_t wdata = 8'h00;
	byte_t rdata, rv;
	logic pin_out, pin_oe_n, irq_req, evt_irq;
	logic [2:0] irq_level;
	logic [7:0] irq_vector;
	logic [31:0] t0;
	logic global_interrupt_permit_flag = 1'b0;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	logic [19:0] regs[9] = '{`A_CLK_SRC, `A_PSC_CTRL, `A_TMR_CTRL, `A_RELOAD, `A_PRIO, `A_INT_EN,
		`A_FACTOR, `A_PORT_FUNC, 20'h40150};
	logic [27:0] init_seq[8] = '{28'h4016000, 28'h4014D07, 28'h4016126, 28'h4014600, 28'h4026903,
		28'h4027501, 28'h4028500, 28'h4014D0F};

	prescaled_8bit_reload_timer prescaled_8bit_reload_timer_inst (.clk(clk), .rst(rst), .ce(ce),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(1'b0),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_req(irq_req), .irq_level(irq_level),
		.irq_vector(irq_vector), .evt_irq(evt_irq));
	////////////////////////////////////////////////////////////////
	// Clock and cycle ceiling
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	// Compare, register access and waiting
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [19:0] a, input byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, output byte_t d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic wait_irq(input logic v, input int n, output logic hit);
		hit = 1'b0;
		repeat (n) begin
			@(negedge clk);
			if ((irq_req & global_interrupt_permit_flag) === v) begin
				hit = 1'b1;
				break;
			end
		end
	endtask
	task automatic quiet(input int n);
		wr(`A_FACTOR, 8'h01);
		wait_irq(1'b0, 8, got);
		check(got, 1);
		wait_irq(1'b1, n, got);
	endtask
	task automatic period(input logic [31:0] exp);
		for (int i = 0; i < 2; i++) begin
			quiet(12000);
			check(got, 1);
			if (i == 0)
				t0 = cyc;
		end
		check(cyc - t0, exp);
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[i]) begin
			rd(regs[i], rv);
			check(rv, 8'h00);
		end
		check(pin_oe_n, 1);
		global_interrupt_permit_flag = 1'b0;
		foreach (init_seq[i]) wr(init_seq[i][27:8], init_seq[i][7:0]);
		global_interrupt_permit_flag = 1'b1;
		rd(`A_RELOAD, rv);
		check(rv, 8'h26);
		check(irq_level, 3);
		wait_irq(1'b1, 10500, got);
		check(got, 0);
		wr(`A_TMR_CTRL, 8'h03);
		rd(`A_TMR_CTRL, rv);
		check(rv, 8'h01);
		period(39 * 256);
		check(irq_vector, 8'h24);
		wr(`A_TMR_CTRL, 8'h00);
		quiet(10500);
		check(got, 0);
		wr(`A_PSC_CTRL, 8'h07);
		wr(`A_TMR_CTRL, 8'h03);
		quiet(10500);
		check(got, 0);
		rd(`A_COUNT, rv);
		check(rv, 8'h26);
		wr(`A_PSC_CTRL, 8'h08);
		wr(`A_TMR_CTRL, 8'h00);
		wr(`A_TMR_CTRL, 8'h02);
		wr(`A_TMR_CTRL, 8'h01);
		period(39 * 2);
		wr(`A_INT_EN, 8'h00);
		quiet(200);
		check(got, 0);
		rd(`A_FACTOR, rv);
		check(rv[0], 1);
		wr(`A_INT_EN, 8'h01);
		wait_irq(1'b1, 4, got);
		check(got, 1);
		// Event raised, cleared by read, masked
		wr(`A_EVT_MASK, 8'h01);
		repeat (200) @(negedge clk);
		check(evt_irq, 1);
		wr(`A_TMR_CTRL, 8'h00);
		rd(`A_EVT_STAT, rv);
		check(rv, 8'h07);
		check(evt_irq, 0);
		wr(`A_EVT_MASK, 8'h00);
		// Pin handed to the port as output
		wr(`A_PORT_FUNC, 8'h04);
		wr(`A_PORT_DATA, 8'h01);
		@(negedge clk);
		check(pin_oe_n, 0);
		check(pin_out, 1);
		// Write lost while the clock enable is low
		@(posedge clk);
		ce <= 1'b0;
		wr(`A_PORT_DATA, 8'h00);
		ce <= 1'b1;
		@(negedge clk);
		check(pin_out, 1);
		give_verdict();
	end
endmodule

// File: verification/reload_timer_monitor.sv
/*
 Port checker for the reload timer.
 Assumes it is bound to the timer top and sees only its ports.
*/
`include "reload_timer_regs.svh"
module reload_timer_checker
	import reload_timer_pkg::*;
(
	// Clock and register port
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	// Outputs watched
	input wire logic pin_oe_n,
	input wire logic irq_req,
	input wire logic [2:0] irq_level,
	input wire logic [7:0] irq_vector,
	input wire logic evt_irq
);
	logic gate_reg;
	logic run_reg;
	wire wr_ok = wr_stb && ce;
	wire hold_x = wr_stb || rst;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Shadow of gate and run bits
	always_ff @(posedge clk) begin
		if (rst) begin
			gate_reg <= 1'b0;
			run_reg <= 1'b0;
		end else if (wr_ok && addr == `A_PSC_CTRL) begin
			gate_reg <= wdata[`PSC_GATE_BIT];
		end else if (wr_ok && addr == `A_TMR_CTRL) begin
			run_reg <= wdata[`CTL_RUN_BIT];
		end
	end
	////////////////////////////////////////////////////////////////
	// Port-level properties; the tick behind a rise was gated one edge before the underflow
	chk_vector_fixed: assert property (irq_vector == `TMR_VECTOR)
		else $error("vector differs");
	chk_reset_state: assert property ($fell(rst) |-> !irq_req && irq_level == 3'h0 && pin_oe_n && !evt_irq)
		else $error("state after reset wrong");
	chk_level_load: assert property (wr_ok && addr == `A_PRIO ##1 ce && !wr_stb ##1 ce
		|-> irq_level == $past(wdata[2:0], 2))
		else $error("priority not passed on");
	chk_level_hold: assert property (!$past(hold_x) && !$past(hold_x, 2) && !$past(wr_stb, 3)
		|-> $stable(irq_level))
		else $error("priority moved alone");
	chk_en_off: assert property (wr_ok && addr == `A_INT_EN && !wdata[`INT_EN_BIT] ##1 ce && !wr_stb
		|=> !irq_req)
		else $error("request without enable");
	chk_req_stands: assert property (irq_req && ce && !wr_stb && !$past(hold_x) |=> irq_req)
		else $error("request dropped alone");
	chk_pin_input: assert property (pin_oe_n && !(wr_ok && addr == `A_PORT_FUNC) |=> pin_oe_n)
		else $error("pin driven unselected");
	chk_gated_rise: assert property ($rose(irq_req)
		|-> $past(wr_stb, 2) || ($past(gate_reg, 3) && $past(run_reg, 2)))
		else $error("request while gated");
endmodule
bind prescaled_8bit_reload_timer reload_timer_checker reload_timer_checker_inst (.clk(clk), .rst(rst),
	.ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .pin_oe_n(pin_oe_n), .irq_req(irq_req),
	.irq_level(irq_level), .irq_vector(irq_vector), .evt_irq(evt_irq));
